// ---- hw/pfce_pkg.sv ----
// constants and types shared by the parallel flash command engine
package pfce_pkg;
    typedef enum logic [1:0] {
        PFCE_OP_READ,
        PFCE_OP_PROG,
        PFCE_OP_SECT,
        PFCE_OP_CHIP
    } pfce_op_t;

    typedef enum logic [2:0] {
        PFCE_PH_IDLE,
        PFCE_PH_SETUP,
        PFCE_PH_PULSE,
        PFCE_PH_SAMPLE,
        PFCE_PH_HOLD,
        PFCE_PH_DONE
    } pfce_ph_t;

    localparam int CLK_PERIOD_PS = 25000;
    // byte program longest time
    localparam int PROG_MAX_NS = 20000;
    localparam int PROG_TMO_CYC = (PROG_MAX_NS * 1000) / CLK_PERIOD_PS;
    // strobe low widths
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETUP_CYC = 1;

    localparam int SECT_OFS_BITS = 12;
    localparam logic [7:0] SECT_ERASE_CODE = 8'h30;
    localparam logic [7:0] CHIP_ERASE_CODE = 8'h10;
    localparam logic [15:0] CHIP_ERASE_ADDR = 16'h5555;
    localparam int PROG_STEPS = 4;
    localparam int ERASE_STEPS = 6;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam logic [1:0] CONFIRM_READS = 2'h2;
endpackage

// ---- hw/pfce_cyc_if.sv ----
// one flash bus cycle request between sequencer and pin driver
`timescale 1ns/1ps
`default_nettype none
interface pfce_cyc_if #(
    parameter int AW = 19
);
    logic req;
    logic wr;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;

    modport master (
        output req,
        output wr,
        output addr,
        output wdata,
        input done,
        input rdata
    );
    modport cycler (
        input req,
        input wr,
        input addr,
        input wdata,
        output done,
        output rdata
    );
endinterface
`default_nettype wire

// ---- hw/pfce_bus_cycle.sv ----
// drives the flash strobes for one write or read cycle
`timescale 1ns/1ps
`default_nettype none
module pfce_bus_cycle #(
    parameter int AW = 19
) (
    input wire logic clk,
    input wire logic rst_n,
    pfce_cyc_if.cycler cyc,
    output logic [AW-1:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [7:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    typedef struct packed {
        pfce_pkg::pfce_ph_t ph;
        logic [7:0] cnt;
        logic wr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe_n;
        logic [AW-1:0] addr;
        logic [7:0] wdata;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] rdata;
        logic done;
    } pfce_cyc_st_t;

    pfce_cyc_st_t r_reg, r_next;

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.s1 = flash_dq_in;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        case (r_reg.ph)
            pfce_pkg::PFCE_PH_IDLE: begin
                // master moves to its next step while done shows, so skip that cycle
                if (cyc.req && !r_reg.done) begin
                    // address settles before chip select falls
                    r_next.ph = pfce_pkg::PFCE_PH_SETUP;
                    r_next.wr = cyc.wr;
                    r_next.addr = cyc.addr;
                    r_next.wdata = cyc.wdata;
                    r_next.dq_oe_n = ~cyc.wr;
                    r_next.cnt = 8'(pfce_pkg::SETUP_CYC);
                end
            end
            pfce_pkg::PFCE_PH_SETUP: begin
                r_next.ce_n = 1'b0;
                if (r_reg.cnt == 8'h01) begin
                    // strobe falls on the same edge as chip select, so the flash takes the address here
                    r_next.ph = pfce_pkg::PFCE_PH_PULSE;
                    r_next.we_n = ~r_reg.wr;
                    r_next.oe_n = r_reg.wr;
                    r_next.cnt = 8'(pfce_pkg::STROBE_CYC);
                end else begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end
            end
            pfce_pkg::PFCE_PH_PULSE: begin
                if (r_reg.cnt == 8'h01) begin
                    if (r_reg.wr) begin
                        // write strobe rises first: data taken on this edge
                        r_next.we_n = 1'b1;
                        r_next.ph = pfce_pkg::PFCE_PH_HOLD;
                    end else begin
                        r_next.ph = pfce_pkg::PFCE_PH_SAMPLE;
                    end
                end else begin
                    r_next.cnt = r_reg.cnt - 8'h01;
                end
            end
            pfce_pkg::PFCE_PH_SAMPLE: begin
                // wait until the synchronised bus is stable
                if (r_reg.s2 == r_reg.s3) begin
                    r_next.rdata = r_reg.s3;
                    r_next.oe_n = 1'b1;
                    r_next.ph = pfce_pkg::PFCE_PH_HOLD;
                end
            end
            pfce_pkg::PFCE_PH_HOLD: begin
                // deselect between cycles
                r_next.ce_n = 1'b1;
                r_next.ph = pfce_pkg::PFCE_PH_DONE;
            end
            pfce_pkg::PFCE_PH_DONE: begin
                r_next.dq_oe_n = 1'b1;
                r_next.done = 1'b1;
                r_next.ph = pfce_pkg::PFCE_PH_IDLE;
            end
            default: begin
                r_next.ph = pfce_pkg::PFCE_PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.ph <= pfce_pkg::PFCE_PH_IDLE;
            r_reg.ce_n <= 1'b1;
            r_reg.oe_n <= 1'b1;
            r_reg.we_n <= 1'b1;
            r_reg.dq_oe_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign cyc.done = r_reg.done;
    assign cyc.rdata = r_reg.rdata;
    assign flash_addr = r_reg.addr;
    assign flash_dq_out = r_reg.wdata;
    assign flash_dq_oe_n = r_reg.dq_oe_n;
    assign flash_ce_n = r_reg.ce_n;
    assign flash_oe_n = r_reg.oe_n;
    assign flash_we_n = r_reg.we_n;
endmodule
`default_nettype wire

// ---- hw/pfce_host.sv ----
// host-side command engine for a byte-wide parallel flash
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Host writes a command with write strobe low while chip select is low.
// - Host erases a sector before programming any byte in it; this engine does not, the caller must erase first.
// - Program is three unlock cycles, one address/data cycle, then internal work.
// - Sector erase is six cycles ending with code and sector address.
// - Chip erase is six cycles ending with code at the fixed address.
// - On apparent completion, read twice more; both must be valid.
module pfce_host #(
    parameter int AW = 19,
    parameter logic [AW-1:0] UNLOCK1_ADDR = '0,
    parameter logic [7:0] UNLOCK1_DATA = 8'h00,
    parameter logic [AW-1:0] UNLOCK2_ADDR = '0,
    parameter logic [7:0] UNLOCK2_DATA = 8'h00,
    parameter logic [7:0] PROG_SETUP_DATA = 8'h00,
    parameter logic [7:0] ERASE_SETUP_DATA = 8'h00,
    parameter logic [31:0] ERASE_TMO_CYC = 32'd40000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire pfce_pkg::pfce_op_t cmd_op,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_error,
    output logic busy,
    output logic [AW-1:0] flash_addr,
    output logic [7:0] flash_dq_out,
    output logic flash_dq_oe_n,
    input wire logic [7:0] flash_dq_in,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n
);
    typedef enum logic [2:0] {
        PFCE_ST_IDLE,
        PFCE_ST_WR,
        PFCE_ST_RD,
        PFCE_ST_POLL
    } pfce_st_t;

    typedef struct packed {
        pfce_st_t st;
        pfce_pkg::pfce_op_t op;
        logic [2:0] step;
        logic [AW-1:0] addr;
        logic [7:0] data;
        logic [7:0] prev;
        logic first;
        logic [1:0] vcnt;
        logic [31:0] tmo;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_error;
    } pfce_host_st_t;

    pfce_host_st_t r_reg, r_next;
    pfce_cyc_if #(.AW(AW)) cyc ();

    logic [AW-1:0] seq_addr;
    logic [7:0] seq_data;
    logic [2:0] last_step;
    logic [31:0] tmo_limit;
    logic stat_ok;

    // unlock sequence table
    always_comb begin
        seq_addr = UNLOCK1_ADDR;
        seq_data = UNLOCK1_DATA;
        case (r_reg.step)
            3'h1, 3'h4: begin
                seq_addr = UNLOCK2_ADDR;
                seq_data = UNLOCK2_DATA;
            end
            3'h2: begin
                seq_data = (r_reg.op == pfce_pkg::PFCE_OP_PROG) ? PROG_SETUP_DATA
                                                                : ERASE_SETUP_DATA;
            end
            default: begin
                seq_addr = UNLOCK1_ADDR;
                seq_data = UNLOCK1_DATA;
            end
        endcase
        if (r_reg.step == last_step) begin
            case (r_reg.op)
                pfce_pkg::PFCE_OP_PROG: begin
                    seq_addr = r_reg.addr;
                    seq_data = r_reg.data;
                end
                pfce_pkg::PFCE_OP_SECT: begin
                    seq_addr = {r_reg.addr[AW-1:pfce_pkg::SECT_OFS_BITS],
                                {pfce_pkg::SECT_OFS_BITS{1'b0}}};
                    seq_data = pfce_pkg::SECT_ERASE_CODE;
                end
                default: begin
                    seq_addr = AW'(pfce_pkg::CHIP_ERASE_ADDR);
                    seq_data = pfce_pkg::CHIP_ERASE_CODE;
                end
            endcase
        end
    end

    always_comb begin
        last_step = (r_reg.op == pfce_pkg::PFCE_OP_PROG) ? 3'(pfce_pkg::PROG_STEPS - 1)
                                                         : 3'(pfce_pkg::ERASE_STEPS - 1);
        tmo_limit = (r_reg.op == pfce_pkg::PFCE_OP_PROG) ? 32'(pfce_pkg::PROG_TMO_CYC)
                                                         : ERASE_TMO_CYC;
        // toggle stopped and poll bit shows final value
        stat_ok = !r_reg.first
                  && (cyc.rdata[pfce_pkg::TOGGLE_BIT] == r_reg.prev[pfce_pkg::TOGGLE_BIT])
                  && ((r_reg.op == pfce_pkg::PFCE_OP_PROG)
                      ? (cyc.rdata[pfce_pkg::POLL_BIT] == r_reg.data[pfce_pkg::POLL_BIT])
                      : cyc.rdata[pfce_pkg::POLL_BIT]);
    end

    assign cyc.req = (r_reg.st != PFCE_ST_IDLE);
    assign cyc.wr = (r_reg.st == PFCE_ST_WR);
    assign cyc.addr = (r_reg.st == PFCE_ST_WR) ? seq_addr : r_reg.addr;
    assign cyc.wdata = seq_data;

    always_comb begin
        r_next = r_reg;
        r_next.rsp_valid = 1'b0;
        case (r_reg.st)
            PFCE_ST_IDLE: begin
                if (cmd_valid) begin
                    r_next.op = cmd_op;
                    r_next.addr = cmd_addr;
                    r_next.data = cmd_data;
                    r_next.step = 3'h0;
                    r_next.tmo = 32'h0;
                    r_next.vcnt = 2'h0;
                    r_next.first = 1'b1;
                    r_next.rsp_error = 1'b0;
                    r_next.st = (cmd_op == pfce_pkg::PFCE_OP_READ) ? PFCE_ST_RD : PFCE_ST_WR;
                end
            end
            PFCE_ST_WR: begin
                // whole sequence is issued back to back, never broken
                if (cyc.done) begin
                    if (r_reg.step == last_step) begin
                        r_next.st = PFCE_ST_POLL;
                    end else begin
                        r_next.step = r_reg.step + 3'h1;
                    end
                end
            end
            PFCE_ST_RD: begin
                if (cyc.done) begin
                    r_next.rsp_data = cyc.rdata;
                    r_next.rsp_valid = 1'b1;
                    r_next.st = PFCE_ST_IDLE;
                end
            end
            PFCE_ST_POLL: begin
                // only status reads until done, so no command is lost
                r_next.tmo = r_reg.tmo + 32'h1;
                if (cyc.done) begin
                    r_next.prev = cyc.rdata;
                    r_next.first = 1'b0;
                    if (stat_ok) begin
                        r_next.vcnt = r_reg.vcnt + 2'h1;
                        if (r_reg.vcnt == pfce_pkg::CONFIRM_READS) begin
                            r_next.rsp_data = cyc.rdata;
                            r_next.rsp_valid = 1'b1;
                            r_next.st = PFCE_ST_IDLE;
                        end
                    end else begin
                        r_next.vcnt = 2'h0;
                    end
                end
                if (r_reg.tmo >= tmo_limit && r_next.st != PFCE_ST_IDLE && cyc.done) begin
                    r_next.rsp_data = cyc.rdata;
                    r_next.rsp_error = 1'b1;
                    r_next.rsp_valid = 1'b1;
                    r_next.st = PFCE_ST_IDLE;
                end
            end
            default: begin
                r_next.st = PFCE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
            r_reg.st <= PFCE_ST_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    pfce_bus_cycle #(.AW(AW)) u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .cyc(cyc.cycler),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_oe_n(flash_dq_oe_n),
        .flash_dq_in(flash_dq_in),
        .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n)
    );

    assign cmd_ready = (r_reg.st == PFCE_ST_IDLE);
    assign busy = (r_reg.st != PFCE_ST_IDLE);
    assign rsp_valid = r_reg.rsp_valid;
    assign rsp_data = r_reg.rsp_data;
    assign rsp_error = r_reg.rsp_error;
endmodule
`default_nettype wire

// ---- dv/pfce_host_checker.sv ----
// bus-side and command-side assertions for the flash command engine
`timescale 1ns/1ps
`default_nettype none
module pfce_host_checker #(
    parameter int AW = 19
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire pfce_pkg::pfce_op_t cmd_op,
    input wire logic rsp_valid,
    input wire logic busy,
    input wire logic [AW-1:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_dq_oe_n,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take = cmd_valid && cmd_ready;
    pfce_pkg::pfce_op_t op_q;
    // last accepted command, so program data never looks like an erase code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= pfce_pkg::PFCE_OP_READ;
        end else if (take) begin
            op_q <= cmd_op;
        end
    end
    property p_we_in_cs;
        !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n;
    endproperty
    a_we_in_cs: assert property (p_we_in_cs) else $error("write strobe outside select");
    property p_rd_release;
        !flash_oe_n |-> flash_dq_oe_n;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("host drives during read");
    property p_hold;
        !flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("address or data moved under select");
    property p_we_width;
        $fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
    property p_ce_after_we;
        $rose(flash_we_n) |=> $rose(flash_ce_n);
    endproperty
    a_ce_after_we: assert property (p_ce_after_we) else $error("select not released");
    property p_rsp_pulse;
        rsp_valid |=> !rsp_valid;
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than one cycle");
    property p_take_busy;
        take |=> busy && !cmd_ready;
    endproperty
    a_take_busy: assert property (p_take_busy) else $error("accept did not start work");
    property p_read_lat;
        take && cmd_op == pfce_pkg::PFCE_OP_READ |-> ##[11:40] rsp_valid;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read answer missing");
    property p_chip_addr;
        !flash_we_n && op_q == pfce_pkg::PFCE_OP_CHIP
            && flash_dq_out == pfce_pkg::CHIP_ERASE_CODE
            |-> flash_addr == AW'(pfce_pkg::CHIP_ERASE_ADDR);
    endproperty
    a_chip_addr: assert property (p_chip_addr) else $error("chip erase address wrong");
    property p_sect_addr;
        !flash_we_n && op_q == pfce_pkg::PFCE_OP_SECT
            && flash_dq_out == pfce_pkg::SECT_ERASE_CODE |-> flash_addr[11:0] == 12'h000;
    endproperty
    a_sect_addr: assert property (p_sect_addr) else $error("sector address not aligned");
    c_prog: cover property (take && cmd_op == pfce_pkg::PFCE_OP_PROG);
    c_sect: cover property (take && cmd_op == pfce_pkg::PFCE_OP_SECT);
    c_chip: cover property (take && cmd_op == pfce_pkg::PFCE_OP_CHIP);
endmodule
bind pfce_host pfce_host_checker #(.AW(AW)) u_chk (
    .clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid, .busy, .flash_addr,
    .flash_dq_out, .flash_dq_oe_n, .flash_ce_n, .flash_oe_n, .flash_we_n
);
`default_nettype wire

// ---- dv/pfce_flash_model.sv ----
// behavioural byte-wide flash facing the command engine
`timescale 1ns/1ps
`default_nettype none
module pfce_flash_model #(
    parameter int AW = 19,
    parameter logic [AW-1:0] U1A = '0,
    parameter logic [7:0] U1D = 8'h00,
    parameter logic [AW-1:0] U2A = '0,
    parameter logic [7:0] U2D = 8'h00,
    parameter logic [7:0] PSD = 8'h00,
    parameter logic [7:0] ESD = 8'h00
) (
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] dq_w,
    input wire logic dq_oe_n,
    output logic [7:0] dq_r,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic slow
);
    logic [7:0] mem [int];
    logic [7:0] last_v, out_v, d, pd;
    logic [AW-1:0] a_lat;
    logic bsy = 1'b0, ers = 1'b0, tog = 1'b0, emode = 1'b0;
    int step = 0;
    wire wr_n = ce_n | we_n;
    wire rd_n = ce_n | oe_n;
    function automatic logic [7:0] rd(input int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    // busy for a fixed time, never aborted
    task automatic run(input int ns, input logic e);
        bsy = 1'b1;
        ers = e;
        fork
            begin
                #(ns);
                bsy = 1'b0;
            end
        join_none
    endtask
    always @(negedge wr_n) a_lat = addr;
    always @(posedge wr_n) begin
        d = dq_r;
        if (!bsy) begin
            if (step == 3 && !emode) begin
                mem[a_lat] = rd(a_lat) & d;
                pd = d;
                step = 0;
                run(5000, 1'b0);
            end else if (step == 5) begin
                step = 0;
                if (d == pfce_pkg::SECT_ERASE_CODE) begin
                    for (int i = 0; i < 4096; i++) mem.delete({a_lat[AW-1:12], 12'h000} + i);
                    run(slow ? 80000 : 10000, 1'b1);
                end else if (d == 8'h10 && a_lat == AW'(pfce_pkg::CHIP_ERASE_ADDR)) begin
                    mem.delete();
                    run(slow ? 80000 : 10000, 1'b1);
                end
            end else if (step == 2) begin
                emode = (d == ESD);
                step = (a_lat == U1A && (d == PSD || d == ESD)) ? 3 : 0;
            end else if (step == 1 || step == 4) begin
                step = (a_lat == U2A && d == U2D) ? step + 1 : 0;
            end else begin
                step = (a_lat == U1A && d == U1D) ? step + 1 : 0;
            end
        end
    end
    always @(negedge rd_n) if (bsy) tog = ~tog;
    assign out_v = bsy ? {ers ? 1'b0 : ~pd[7], tog, 6'h00} : rd(addr);
    // released bus shows the inverse of what was last on it
    always @* begin
        if (!dq_oe_n) last_v = dq_w;
        else if (!rd_n) last_v = out_v;
    end
    assign dq_r = !dq_oe_n ? dq_w : (!rd_n ? out_v : ~last_v);
endmodule
`default_nettype wire

// ---- dv/test_parallel_flash_command_engine.sv ----
// self-checking bench for the parallel flash command engine
`timescale 1ns/1ps
`default_nettype none
module test_parallel_flash_command_engine;
    localparam logic [18:0] U1A = 19'h00aaa;
    localparam logic [18:0] U2A = 19'h00555;
    localparam int ADDR_W = 19;
    localparam logic [7:0] U1D = 8'h5a;
    localparam logic [7:0] U2D = 8'ha5;
    localparam logic [7:0] PSD = 8'h3c;
    localparam logic [7:0] ESD = 8'hc3;
    localparam logic [31:0] ERASE_TMO = 32'h7d0;
    logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, slow = 1'b0, got_e;
    pfce_pkg::pfce_op_t cmd_op = pfce_pkg::PFCE_OP_READ;
    logic [18:0] cmd_addr = '0, f_addr;
    logic [7:0] cmd_data = '0, rsp_data, dq_out, dq_in, got_d;
    logic cmd_ready, rsp_valid, rsp_error, busy, dq_oe_n, ce_n, oe_n, we_n;
    int n_errors = 0, tests_run = 0, cyc = 0;
    initial begin
        forever #12.5 clk = ~clk;
    end
    pfce_host #(.AW(ADDR_W), .UNLOCK1_ADDR(U1A), .UNLOCK1_DATA(U1D), .UNLOCK2_ADDR(U2A),
        .UNLOCK2_DATA(U2D), .PROG_SETUP_DATA(PSD), .ERASE_SETUP_DATA(ESD),
        .ERASE_TMO_CYC(ERASE_TMO)) dut_u (
        .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_error(rsp_error), .busy(busy), .flash_addr(f_addr),
        .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in),
        .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
    pfce_flash_model #(.AW(ADDR_W), .U1A(U1A), .U1D(U1D), .U2A(U2A), .U2D(U2D),
        .PSD(PSD), .ESD(ESD)) flash_u (
        .addr(f_addr), .dq_w(dq_out), .dq_oe_n(dq_oe_n), .dq_r(dq_in), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .slow(slow));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input pfce_pkg::pfce_op_t op, input logic [18:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 6000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("response", 8'h01, {7'h00, rsp_valid});
        got_d = rsp_data;
        got_e = rsp_error;
    endtask
    task automatic t_reset();
        chk("idle pins", 8'h3e, {2'h0, ce_n, oe_n, we_n, dq_oe_n, cmd_ready, busy});
        $display("reset test done");
    endtask
    task automatic t_prog();
        cmd(pfce_pkg::PFCE_OP_CHIP, 19'h00000, 8'h00);
        chk("pre-erase error", 8'h00, {7'h00, got_e});
        cmd(pfce_pkg::PFCE_OP_PROG, 19'h01004, 8'h5a);
        chk("prog status", 8'h5a, got_d);
        chk("prog error", 8'h00, {7'h00, got_e});
        cmd(pfce_pkg::PFCE_OP_PROG, 19'h02010, 8'h81);
        chk("prog status 2", 8'h81, got_d);
        cmd(pfce_pkg::PFCE_OP_READ, 19'h01004, 8'h00);
        chk("read back", 8'h5a, got_d);
        cmd(pfce_pkg::PFCE_OP_READ, 19'h02010, 8'h00);
        chk("read back 2", 8'h81, got_d);
        $display("program test done");
    endtask
    task automatic t_sect();
        cmd(pfce_pkg::PFCE_OP_SECT, 19'h01abc, 8'h00);
        chk("erase status", 8'hff, got_d);
        cmd(pfce_pkg::PFCE_OP_READ, 19'h01004, 8'h00);
        chk("erased byte", 8'hff, got_d);
        cmd(pfce_pkg::PFCE_OP_READ, 19'h02010, 8'h00);
        chk("other sector", 8'h81, got_d);
        $display("sector erase test done");
    endtask
    task automatic t_chip();
        cmd(pfce_pkg::PFCE_OP_CHIP, 19'h00000, 8'h00);
        chk("chip error", 8'h00, {7'h00, got_e});
        cmd(pfce_pkg::PFCE_OP_READ, 19'h02010, 8'h00);
        chk("chip erased", 8'hff, got_d);
        $display("chip erase test done");
    endtask
    task automatic t_tmo();
        int n;
        slow = 1'b1;
        cmd(pfce_pkg::PFCE_OP_SECT, 19'h03000, 8'h00);
        chk("erase timeout", 8'h01, {7'h00, got_e});
        cmd(pfce_pkg::PFCE_OP_READ, 19'h03000, 8'h00);
        chk("busy poll bit", 8'h00, {7'h00, got_d[7]});
        n = 0;
        while (got_d !== 8'hff && n < 500) begin
            cmd(pfce_pkg::PFCE_OP_READ, 19'h03000, 8'h00);
            n++;
        end
        chk("after erase", 8'hff, got_d);
        slow = 1'b0;
        $display("timeout test done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_prog();
        t_sect();
        t_chip();
        t_tmo();
        wrap_up();
    end
endmodule
`default_nettype wire
